// ### shared/adpm_pkg.sv
// Timing constants and types for the page-mode memory controller
`default_nettype none
package adpm_pkg;
    localparam int CLK_PERIOD_NS      = 8;
    // Widths
    localparam int LOC_W              = 21;
    localparam int ROW_W              = 12;
    localparam int COL_W              = 9;
    localparam int BYTE_W             = 8;
    // Times as printed, ns unless the name says otherwise, fastest grade
    localparam int RC_NS              = 110;
    localparam int RP_NS              = 40;
    localparam int RAS_MIN_NS         = 60;
    localparam int RAS_MAX_NS         = 10000;
    localparam int RASP_MAX_NS        = 100000;
    localparam int PC_NS              = 40;
    localparam int CP_NS              = 10;
    localparam int CAS_MIN_NS         = 15;
    localparam int RAH_NS             = 10;
    localparam int RCD_NS             = 20;
    localparam int ROW_HOLD_NS        = 15;
    localparam int RAC_NS             = 60;
    localparam int CAC_NS             = 15;
    localparam int CAA_NS             = 30;
    localparam int CPA_NS             = 35;
    localparam int WCH_NS             = 15;
    localparam int RRH_NS             = 5;
    localparam int CWD_NS             = 40;
    localparam int RWD_NS             = 85;
    localparam int RWC_NS             = 155;
    localparam int CWL_NS             = 15;
    localparam int CSR_NS             = 10;
    localparam int CHR_NS             = 20;
    localparam int RPS_NS             = 110;
    localparam int SELF_ENTRY_US      = 100;
    localparam int REFRESH_PERIOD_MS  = 64;
    localparam int REFRESH_LP_MS      = 512;
    localparam int REFRESH_ROWS       = 4096;
    // Cycle counts: minimums round up, maximums round down
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int cyc_max(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RP_CYC    = cyc_min(RP_NS);
    localparam int RAS_CYC   = cyc_min(RAS_MIN_NS);
    localparam int RC_CYC    = cyc_min(RC_NS);
    localparam int PC_CYC    = cyc_min(PC_NS);
    localparam int CP_CYC    = cyc_min(CP_NS);
    localparam int CAS_CYC   = cyc_min(CAS_MIN_NS);
    localparam int RAH_CYC   = cyc_min(RAH_NS);
    localparam int RCD_CYC   = cyc_min(RCD_NS);
    localparam int RSH_CYC   = cyc_min(ROW_HOLD_NS);
    localparam int RAC_CYC   = cyc_min(RAC_NS);
    localparam int CAC_CYC   = cyc_min(CAC_NS);
    localparam int CAA_CYC   = cyc_min(CAA_NS);
    localparam int CPA_CYC   = cyc_min(CPA_NS);
    localparam int WCH_CYC   = cyc_min(WCH_NS);
    localparam int RRH_CYC   = cyc_min(RRH_NS);
    localparam int CWD_CYC   = cyc_min(CWD_NS);
    localparam int RWD_CYC   = cyc_min(RWD_NS);
    localparam int RWC_CYC   = cyc_min(RWC_NS);
    localparam int CWL_CYC   = cyc_min(CWL_NS);
    localparam int CSR_CYC   = cyc_min(CSR_NS);
    localparam int CHR_CYC   = cyc_min(CHR_NS);
    localparam int RPS_CYC   = cyc_min(RPS_NS);
    localparam int RASP_MAX_CYC = cyc_max(RASP_MAX_NS);
    localparam int RAS_MAX_CYC  = cyc_max(RAS_MAX_NS);
    // Long counts; defaults of top-level parameters
    localparam int SELF_ENTRY_CYC = (SELF_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFI_CYC = int'((64'(REFRESH_PERIOD_MS) * 1000000)
                              / (64'(REFRESH_ROWS) * CLK_PERIOD_NS));
    localparam int TMR_W = 16;
    // Request kinds
    typedef enum logic [1:0] {
        ADPM_OP_READ, ADPM_OP_WRITE, ADPM_OP_RMW
    } adpm_op_t;
endpackage : adpm_pkg
`default_nettype wire

// ### core/adpm_ctrl.sv
// Page-mode memory controller driving strobes, location lines and byte lines
// Functional notes
// - Refresh every row within refresh period.
// - Row strobe low time bounded, page longer.
// - Random cycle 110 ns, precharge 40 ns.
// - Page column cycle 40 ns, high 10.
// - Column setup covers column strobe high time.
// - Sample read data after all access times.
// - Write data referenced to later falling edge.
// - Read keeps write enable high past strobes.
// - Early write: enable low before column strobe.
// - Modify-write: enable late, cycle 155 ns.
// - Column-first refresh lead and hold times.
// - Self refresh after 100 us both low.
// - After self refresh, precharge 110 ns.
// - Page bursts may mix read and write.
// - Exceeding row-to-column delay is tolerated.
// - Row strobe low 15 ns after column fall.
// - Write enable high reads, low writes.
// - 21-bit index: 12 row, 9 column bits.
`default_nettype none
module adpm_ctrl
#(
    parameter int REFI_CYCLES  = adpm_pkg::REFI_CYC,
    parameter int SELF_CYCLES  = adpm_pkg::SELF_ENTRY_CYC,
    parameter int PAGE_MAX_CYC = adpm_pkg::RASP_MAX_CYC
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    // Host request
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire adpm_pkg::adpm_op_t        req_op,
    input  wire logic [adpm_pkg::LOC_W-1:0] req_loc,
    input  wire logic [adpm_pkg::BYTE_W-1:0] req_wdata,
    input  wire logic [adpm_pkg::BYTE_W-1:0] req_mdata,
    // Host answer
    output logic                           rsp_valid,
    output logic [adpm_pkg::BYTE_W-1:0]    rsp_rdata,
    // Power control
    input  wire logic                      self_refresh_req,
    output logic                           self_refresh_active,
    // Memory pins
    output logic                           row_strobe_n,
    output logic                           column_strobe_n,
    output logic                           write_enable_n,
    output logic                           output_enable_n,
    output logic [adpm_pkg::ROW_W-1:0]     muxed_location_lines,
    input  wire logic [adpm_pkg::BYTE_W-1:0] byte_lines_i,
    output logic [adpm_pkg::BYTE_W-1:0]    byte_lines_o,
    output logic                           byte_lines_oe
);
    import adpm_pkg::*;

    initial begin
        if (REFI_CYCLES < 64 || REFI_CYCLES >= 2**TMR_W * 16 ||
            SELF_CYCLES < 1 || PAGE_MAX_CYC < 64 || PAGE_MAX_CYC > RASP_MAX_CYC) begin
            $error("adpm_ctrl: unsupported parameter value");
        end
    end

    typedef enum logic [3:0] {
        S_IDLE, S_ROW,
        S_COLSET, S_COL,
        S_WAITCOL, S_PRE,
        S_CFR_LEAD, S_CFR_ROW,
        S_SELF, S_SELF_EXIT
    } adpm_state_t;

    typedef struct packed {
        adpm_state_t          st;
        logic                 ras_n;
        logic                 cas_n;
        logic                 we_n;
        logic                 oe_n;
        logic [ROW_W-1:0]     addr;
        logic [BYTE_W-1:0]    dout;
        logic                 doe;
        logic [BYTE_W-1:0]    rdata;
        logic                 rvalid;
        adpm_op_t             op;
        logic [LOC_W-1:0]     loc;
        logic [BYTE_W-1:0]    mdata;
        logic [TMR_W-1:0]     t;
        logic [TMR_W-1:0]     tcas;
        logic [TMR_W-1:0]     tcyc;
        logic [23:0]          tras;
        logic [23:0]          refi;
        logic [3:0]           owed;
        logic [BYTE_W-1:0]    sync1;
        logic [BYTE_W-1:0]    sync2;
    } adpm_regs_t;

    adpm_regs_t r_q;
    adpm_regs_t r_d;

    logic same_row;
    logic cyc_ok;
    logic page_room;

    assign same_row  = (req_loc[LOC_W-1:COL_W] == r_q.loc[LOC_W-1:COL_W]);
    // Row strobe must stay low through a full cycle
    assign page_room = (r_q.tras < 24'(PAGE_MAX_CYC - 2 * RWC_CYC));
    assign cyc_ok    = (r_q.tcyc >= TMR_W'(PC_CYC));
    assign req_ready = (r_q.st == S_WAITCOL) && r_q.owed == 4'h0 && !self_refresh_req
                       && page_room && cyc_ok && same_row && req_valid;

    always_comb begin
        r_d        = r_q;
        r_d.sync1  = byte_lines_i;
        r_d.sync2  = r_q.sync1;
        r_d.rvalid = 1'b0;
        r_d.t      = r_q.t + 1'b1;
        r_d.tcas   = r_q.tcas + 1'b1;
        r_d.tcyc   = r_q.tcyc + 1'b1;
        r_d.tras   = r_q.ras_n ? 24'h0 : r_q.tras + 1'b1;
        // Owed refreshes accumulate, saturating at 15
        if (r_q.refi >= 24'(REFI_CYCLES - 1)) begin
            r_d.refi = 24'h0;
            if (r_q.owed != 4'hf) begin
                r_d.owed = r_q.owed + 1'b1;
            end
        end else begin
            r_d.refi = r_q.refi + 1'b1;
        end
        unique case (r_q.st)
            S_IDLE: begin
                if (r_q.owed != 4'h0 || self_refresh_req) begin
                    r_d.cas_n = 1'b0;
                    r_d.addr  = '0;
                    r_d.t     = '0;
                    r_d.st    = S_CFR_LEAD;
                end else if (req_valid) begin
                    r_d.op    = req_op;
                    r_d.loc   = req_loc;
                    r_d.mdata = req_mdata;
                    r_d.dout  = req_wdata;
                    r_d.addr  = req_loc[LOC_W-1:COL_W];
                    r_d.ras_n = 1'b0;
                    r_d.t     = '0;
                    r_d.tcyc  = '0;
                    r_d.st    = S_ROW;
                end
            end
            S_ROW: begin
                // Column lines after row hold; flow-through latch starts access
                if (r_q.t + 1'b1 >= TMR_W'(RAH_CYC)) begin
                    r_d.addr = ROW_W'(r_q.loc[COL_W-1:0]);
                    r_d.we_n = (r_q.op != ADPM_OP_WRITE);
                    r_d.doe  = (r_q.op == ADPM_OP_WRITE);
                    r_d.oe_n = (r_q.op == ADPM_OP_WRITE);
                    r_d.t    = '0;
                    r_d.st   = S_COLSET;
                end
            end
            S_COLSET: begin
                // Setup at least the column-high time before the fall
                if (r_q.t + 1'b1 >= TMR_W'(CP_CYC) && r_q.tras + 1'b1 >= 24'(RCD_CYC)) begin
                    r_d.cas_n = 1'b0;
                    r_d.t     = '0;
                    r_d.tcas  = '0;
                    r_d.st    = S_COL;
                end
            end
            S_COL: begin
                if (r_q.op == ADPM_OP_WRITE) begin
                    // Early write: hold enable and data past the fall
                    if (r_q.t + 1'b1 >= TMR_W'(WCH_CYC)) begin
                        r_d.cas_n = 1'b1;
                        r_d.we_n  = 1'b1;
                        r_d.doe   = 1'b0;
                        r_d.rvalid = 1'b1;
                        r_d.t     = '0;
                        r_d.st    = S_WAITCOL;
                    end
                end else if (r_q.we_n && r_q.oe_n) begin
                    // Drive modify data only once the memory has floated
                    r_d.doe = (r_q.t + 1'b1 >= TMR_W'(CAC_CYC));
                    if (r_q.doe && r_q.tcas >= TMR_W'(CWD_CYC)
                        && r_q.tras >= 24'(RWD_CYC)) begin
                        r_d.we_n = 1'b0;
                        r_d.t    = '0;
                    end
                end else if (r_q.we_n) begin
                    // Sample only after every access time has passed
                    if (r_q.tras >= 24'(RAC_CYC + 2) && r_q.t >= TMR_W'(CAC_CYC + 2)
                        && r_q.t >= TMR_W'(CAA_CYC + 2)) begin
                        r_d.rdata = r_q.sync2;
                        r_d.oe_n  = 1'b1;
                        r_d.t     = '0;
                        if (r_q.op == ADPM_OP_RMW) begin
                            r_d.dout = r_q.mdata;
                        end else begin
                            r_d.cas_n  = 1'b1;
                            r_d.rvalid = 1'b1;
                            r_d.st     = S_WAITCOL;
                        end
                    end
                end else begin
                    // Modify-write: hold write low and data driven
                    if (r_q.t >= TMR_W'(CAC_CYC + CWL_CYC)) begin
                        r_d.cas_n  = 1'b1;
                        r_d.we_n   = 1'b1;
                        r_d.doe    = 1'b0;
                        r_d.rvalid = 1'b1;
                        r_d.t      = '0;
                        r_d.st     = S_WAITCOL;
                    end
                end
            end
            S_WAITCOL: begin
                if (req_ready) begin
                    // Next column of the open page
                    r_d.op    = req_op;
                    r_d.loc   = req_loc;
                    r_d.mdata = req_mdata;
                    r_d.dout  = req_wdata;
                    r_d.addr  = ROW_W'(req_loc[COL_W-1:0]);
                    r_d.we_n  = (req_op != ADPM_OP_WRITE);
                    r_d.doe   = (req_op == ADPM_OP_WRITE);
                    r_d.oe_n  = (req_op == ADPM_OP_WRITE);
                    r_d.tcyc  = '0;
                    r_d.t     = '0;
                    r_d.st    = S_COLSET;
                end else if (!req_valid || !same_row || !page_room || r_q.owed != 4'h0
                             || self_refresh_req) begin
                    // Close the row once its times are met
                    if (r_q.tras + 1'b1 >= 24'(RAS_CYC) && r_q.t + 1'b1 >= TMR_W'(RSH_CYC)
                        && r_q.t >= TMR_W'(RRH_CYC)
                        && r_q.tcyc + 1'b1 >= TMR_W'((r_q.op == ADPM_OP_RMW) ? RWC_CYC
                                                     : RC_CYC - RP_CYC)) begin
                        r_d.ras_n = 1'b1;
                        r_d.addr  = '0;
                        r_d.t     = '0;
                        r_d.st    = S_PRE;
                    end
                end
            end
            S_PRE: begin
                if (r_q.t + 1'b1 >= TMR_W'(RP_CYC)) begin
                    r_d.t  = '0;
                    r_d.st = S_IDLE;
                end
            end
            S_CFR_LEAD: begin
                if (r_q.t + 1'b1 >= TMR_W'(CSR_CYC)) begin
                    r_d.ras_n = 1'b0;
                    r_d.t     = '0;
                    r_d.st    = S_CFR_ROW;
                end
            end
            S_CFR_ROW: begin
                if (self_refresh_req) begin
                    r_d.t  = '0;
                    r_d.st = S_SELF;
                end else if (r_q.t + 1'b1 >= TMR_W'(RAS_CYC) && r_q.t >= TMR_W'(CHR_CYC)) begin
                    r_d.ras_n = 1'b1;
                    r_d.cas_n = 1'b1;
                    r_d.owed  = r_q.owed - ((r_q.owed != 4'h0) ? 4'h1 : 4'h0);
                    if (r_d.refi == 24'h0 && r_q.owed != 4'hf) begin
                        r_d.owed = r_q.owed; // Tick and retire in one cycle
                    end
                    r_d.t     = '0;
                    r_d.st    = S_PRE;
                end
            end
            S_SELF: begin
                // Long count rides on the row-low counter
                if (!self_refresh_req && r_q.tras >= 24'(SELF_CYCLES)) begin
                    r_d.ras_n = 1'b1;
                    r_d.cas_n = 1'b1;
                    r_d.t     = '0;
                    r_d.owed  = 4'hf; // Burst refresh after exit
                    r_d.st    = S_SELF_EXIT;
                end
            end
            S_SELF_EXIT: begin
                if (r_q.t + 1'b1 >= TMR_W'(RPS_CYC)) begin
                    r_d.t  = '0;
                    r_d.st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            r_q       <= '0;
            r_q.st    <= S_IDLE;
            r_q.ras_n <= 1'b1;
            r_q.cas_n <= 1'b1;
            r_q.we_n  <= 1'b1;
            r_q.oe_n  <= 1'b1;
            r_q.op    <= ADPM_OP_READ;
        end else begin
            r_q <= r_d;
        end
    end

    assign row_strobe_n         = r_q.ras_n;
    assign column_strobe_n      = r_q.cas_n;
    assign write_enable_n       = r_q.we_n;
    assign output_enable_n      = r_q.oe_n;
    assign muxed_location_lines = r_q.addr;
    assign byte_lines_o         = r_q.dout;
    assign byte_lines_oe        = r_q.doe;
    assign rsp_valid            = r_q.rvalid;
    assign rsp_rdata            = r_q.rdata;
    assign self_refresh_active  = (r_q.st == S_SELF);

endmodule : adpm_ctrl
`default_nettype wire

// ### tb/adpm_ctrl_checker.sv
// Pin timing checker for the page-mode memory controller
`default_nettype none
module adpm_ctrl_checker
    import adpm_pkg::*;
#(
    parameter int REFI_CYCLES  = 200,
    parameter int SELF_CYCLES  = 100,
    parameter int PAGE_MAX_CYC = 500
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched outputs
    input wire logic self_refresh_active,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic byte_lines_oe
);
    // Counters; reset values let the first cycles pass
    logic [15:0] hi_q, rc_q, cc_q, rlo_q, clo_q, gap_q;
    logic        sr_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hi_q  <= 16'h00ff;
            rc_q  <= 16'h00ff;
            cc_q  <= 16'h00ff;
            rlo_q <= 16'h0000;
            clo_q <= 16'h0000;
            gap_q <= 16'h0000;
            sr_q  <= 1'b0;
        end else begin
            hi_q  <= row_strobe_n ? hi_q + 16'h0001 : 16'h0000;
            rlo_q <= row_strobe_n ? 16'h0000 : rlo_q + 16'h0001;
            clo_q <= column_strobe_n ? 16'h0000 : clo_q + 16'h0001;
            rc_q  <= $fell(row_strobe_n) ? 16'h0001 : rc_q + 16'h0001;
            cc_q  <= $fell(column_strobe_n) ? 16'h0001 : cc_q + 16'h0001;
            gap_q <= (self_refresh_active || ($fell(row_strobe_n) && !column_strobe_n)) ?
                     16'h0000 : gap_q + 16'h0001;
            sr_q  <= $fell(self_refresh_active) ? 1'b1 : ($fell(row_strobe_n) ? 1'b0 : sr_q);
        end
    end
    sequence s_col_fall_open;
        $fell(column_strobe_n) && !row_strobe_n;
    endsequence
    sequence s_refresh_start;
        $fell(row_strobe_n) && !column_strobe_n;
    endsequence
    a_precharge_min: assert property ($rose(row_strobe_n) |-> row_strobe_n[*5])
        else $error("precharge short");
    a_cycle_time: assert property ($fell(row_strobe_n) |-> rc_q >= RC_CYC)
        else $error("cycle short");
    a_self_exit: assert property ($fell(row_strobe_n) && sr_q |-> hi_q >= RPS_CYC)
        else $error("self exit precharge short");
    a_row_low_max: assert property (!row_strobe_n |-> rlo_q <= PAGE_MAX_CYC)
        else $error("row low too long");
    a_column_high: assert property ($rose(column_strobe_n) && !row_strobe_n |-> column_strobe_n[*2])
        else $error("column high short");
    a_page_cycle: assert property (s_col_fall_open ##0 $past(!row_strobe_n) |-> cc_q >= PC_CYC)
        else $error("page cycle short");
    a_row_hold: assert property (s_col_fall_open |-> !row_strobe_n[*2])
        else $error("row hold short");
    a_refresh_lead: assert property (s_refresh_start |-> clo_q >= CSR_CYC ##1 !column_strobe_n[*2])
        else $error("refresh lead or hold short");
    a_write_hold: assert property (s_col_fall_open ##0 !write_enable_n |-> !write_enable_n[*2])
        else $error("write hold short");
    a_modify_delay: assert property ($fell(write_enable_n) && !column_strobe_n && $past(!column_strobe_n) |-> clo_q >= CWD_CYC && rlo_q >= RWD_CYC)
        else $error("modify write early");
    a_bus_turn: assert property (byte_lines_oe |-> output_enable_n)
        else $error("bus driven with outputs on");
    a_refresh_gap: assert property (gap_q <= REFI_CYCLES + PAGE_MAX_CYC + 64)
        else $error("refresh gap long");
endmodule // adpm_ctrl_checker
bind adpm_ctrl adpm_ctrl_checker #(
    .REFI_CYCLES(REFI_CYCLES), .SELF_CYCLES(SELF_CYCLES), .PAGE_MAX_CYC(PAGE_MAX_CYC)
) u_checker (
    .core_clk, .rst, .self_refresh_active, .row_strobe_n, .column_strobe_n,
    .write_enable_n, .output_enable_n, .byte_lines_oe
);
`default_nettype wire

// ### tb/adpm_mem_model.sv
// Model of the page-mode memory at the controller pins
`default_nettype none
module adpm_mem_model
    import adpm_pkg::*;
#(
    parameter int SELF_NS = 800
) (
    // Strobes and location
    input  wire logic                        row_strobe_n,
    input  wire logic                        column_strobe_n,
    input  wire logic                        write_enable_n,
    input  wire logic                        output_enable_n,
    input  wire logic [adpm_pkg::ROW_W-1:0]  muxed_location_lines,
    // Shared byte lines
    input  wire logic [adpm_pkg::BYTE_W-1:0] bus_level,
    output logic      [adpm_pkg::BYTE_W-1:0] mem_out,
    output logic                             mem_oe,
    // Observation
    output int                               refresh_count,
    output logic                             self_entered
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [BYTE_W-1:0] mem [int];
    logic [ROW_W-1:0]  row_q;
    logic [LOC_W-1:0]  loc_q;
    logic              early_q = 1'b0;
    logic              rf_q = 1'b0;
    realtime           row_t = 0, addr_t = 0, valid_t = 0;
    initial begin
        mem_out = 8'h00;
        refresh_count = 0;
        self_entered = 1'b0;
    end
    always @(muxed_location_lines) addr_t = $realtime;
    always @(negedge row_strobe_n) begin
        row_t = $realtime;
        row_q = muxed_location_lines;
        rf_q = !column_strobe_n;
        if (rf_q) refresh_count++;
    end
    // A long column-first start counts as self refresh
    always @(posedge row_strobe_n) begin
        if (rf_q && $realtime - row_t >= SELF_NS) self_entered = 1'b1;
        rf_q = 1'b0;
    end
    always @(negedge column_strobe_n) if (!row_strobe_n) begin
        loc_q = {row_q, muxed_location_lines[COL_W-1:0]};
        early_q = !write_enable_n;
        valid_t = row_t + RAC_NS;
        if (valid_t < $realtime + CAC_NS) valid_t = $realtime + CAC_NS;
        if (valid_t < addr_t + CAA_NS) valid_t = addr_t + CAA_NS;
        #1 if (early_q) mem[loc_q] = bus_level;
    end
    always @(negedge write_enable_n)
        if (!column_strobe_n && !row_strobe_n) #1 mem[loc_q] = bus_level;
    // Lines toggle until valid so a stale sample fails
    always #1 begin
        mem_oe = !column_strobe_n && !output_enable_n && !early_q;
        if (mem_oe && $realtime >= valid_t) mem_out = mem.exists(loc_q) ? mem[loc_q] : 8'h00;
        else mem_out = ~mem_out;
    end
endmodule // adpm_mem_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the page-mode memory controller
`default_nettype none
module testbench
    import adpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REFI = 200;
    localparam int SELF = 100;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_valid = 1'b0;
    logic              self_refresh_req = 1'b0;
    adpm_op_t          req_op = ADPM_OP_READ;
    logic [LOC_W-1:0]  req_loc = 21'h000000;
    logic [BYTE_W-1:0] req_wdata = 8'h00, req_mdata = 8'h00;
    logic              req_ready, rsp_valid, sr_act, row_strobe_n, column_strobe_n;
    logic              write_enable_n, output_enable_n, byte_lines_oe;
    logic [ROW_W-1:0]  muxed_location_lines;
    logic [BYTE_W-1:0] rsp_rdata, byte_lines_o, mem_out;
    wire  [BYTE_W-1:0] bus_level = byte_lines_oe ? byte_lines_o : mem_out;
    int                err_total = 0, num_checks = 0;
    logic [8:0]        exp_q[$];
    logic [7:0]        got[$];
    logic [7:0]        ref_mem [int];
    adpm_ctrl #(.REFI_CYCLES(REFI), .SELF_CYCLES(SELF), .PAGE_MAX_CYC(500)) dut (
        .core_clk, .rst, .req_valid, .req_ready, .req_op, .req_loc, .req_wdata, .req_mdata,
        .rsp_valid, .rsp_rdata, .self_refresh_req, .self_refresh_active(sr_act), .row_strobe_n,
        .column_strobe_n, .write_enable_n, .output_enable_n, .muxed_location_lines,
        .byte_lines_i(bus_level), .byte_lines_o, .byte_lines_oe);
    adpm_mem_model #(.SELF_NS(SELF * CLK_PERIOD_NS)) mdl (
        .row_strobe_n, .column_strobe_n, .write_enable_n, .output_enable_n,
        .muxed_location_lines, .bus_level, .mem_out, .mem_oe(), .refresh_count(),
        .self_entered());
    initial forever #4 core_clk = ~core_clk;
    always @(negedge core_clk) if (rsp_valid === 1'b1) got.push_back(rsp_rdata);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, seen);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic timeout(input string what);
        err_total++;
        $display("CHECK FAILED %s expected done seen timeout", what);
        report_and_stop();
    endtask
    // Holds the request until it is taken
    task automatic issue(input adpm_op_t op, input logic [20:0] loc,
                         input logic [7:0] wd = 8'h00, md = 8'h00);
        logic hit, was_hi;
        @(posedge core_clk);
        {req_op, req_loc, req_wdata, req_mdata, req_valid} <= {op, loc, wd, md, 1'b1};
        exp_q.push_back({op != ADPM_OP_WRITE, ref_mem.exists(loc) ? ref_mem[loc] : 8'h00});
        if (op != ADPM_OP_READ) ref_mem[loc] = (op == ADPM_OP_WRITE) ? wd : md;
        for (int n = 0; n < 3000; n++) begin
            @(posedge core_clk);
            hit = req_ready;
            was_hi = row_strobe_n;
            #1;
            if (hit === 1'b1 || (was_hi === 1'b1 && !row_strobe_n && column_strobe_n)) return;
        end
        timeout("request");
    endtask
    task automatic drain(input string what);
        logic [8:0] e;
        @(posedge core_clk);
        req_valid <= 1'b0;
        for (int n = 0; n < 2000 && got.size() < exp_q.size(); n++) @(posedge core_clk);
        if (got.size() < exp_q.size()) timeout(what);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[8]) check(what, {8'h00, e[7:0]}, {8'h00, got[0]});
            void'(got.pop_front());
        end
        repeat (30) @(posedge core_clk);
        check("spare answers", 16'h0000, 16'(got.size()));
        $display("test %s done", what);
    endtask
    task automatic wait_act(input logic lvl);
        for (int n = 0; n < 3000 && sr_act !== lvl; n++) @(posedge core_clk);
        if (sr_act !== lvl) timeout("self state");
    endtask
    task automatic t_reset();
        #1;
        check("idle pins", 16'h003c, {10'h000, row_strobe_n, column_strobe_n, write_enable_n,
              output_enable_n, byte_lines_oe, rsp_valid});
        $display("test reset done");
    endtask
    task automatic t_basic();
        issue(ADPM_OP_WRITE, 21'h000000, 8'h5a);
        issue(ADPM_OP_WRITE, 21'h1fffff, 8'ha5);
        issue(ADPM_OP_WRITE, 21'h0aa155, 8'h3c);
        issue(ADPM_OP_READ, 21'h1fffff);
        issue(ADPM_OP_READ, 21'h000000, 8'hff);
        issue(ADPM_OP_READ, 21'h0aa155);
        drain("basic");
        check("stored byte", 16'h003c, {8'h00, mdl.mem[21'h0aa155]});
    endtask
    task automatic t_page();
        issue(ADPM_OP_WRITE, {12'h3c5, 9'h001}, 8'h11);
        issue(ADPM_OP_READ, {12'h3c5, 9'h001});
        issue(ADPM_OP_RMW, {12'h3c5, 9'h1ff}, 8'h00, 8'h77);
        issue(ADPM_OP_RMW, {12'h3c5, 9'h1ff}, 8'h00, 8'h88);
        issue(ADPM_OP_READ, {12'h3c5, 9'h1ff});
        drain("page");
    endtask
    task automatic t_refresh();
        int n0;
        n0 = mdl.refresh_count;
        repeat (1500) @(posedge core_clk);
        check("refresh count", 16'h0001, 16'(mdl.refresh_count - n0 >= 1500 / REFI - 1));
        $display("test refresh done");
    endtask
    task automatic t_self();
        @(posedge core_clk);
        self_refresh_req <= 1'b1;
        wait_act(1'b1);
        repeat (SELF + 20) @(posedge core_clk);
        self_refresh_req <= 1'b0;
        wait_act(1'b0);
        check("self entry", 16'h0001, {15'h0000, mdl.self_entered});
        issue(ADPM_OP_READ, 21'h0aa155);
        drain("self");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_basic();
        t_page();
        t_refresh();
        t_self();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
